// ### core/lrw_axil.sv
// AXI4-Lite slave holding control and partner words of the lane mapper.
// Assumes one outstanding write and one outstanding read per master.
`timescale 1ns/1ps
`default_nettype none
module lrw_axil (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] ctrl_q,
   output logic [31:0] partner_q,
   output logic start_pulse,
   input wire logic [31:0] status,
   input wire logic [31:0] cap
);
   import lrw_pkg::*;
   logic aw_hold_q, w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic aw_take, w_take;

   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign do_write = aw_hold_q && w_hold_q && !bvalid;

   // Ready flags registered from the next hold and response state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
      end else begin
         awready <= !do_write && !(aw_hold_q || aw_take) && !(bvalid && !bready);
         wready <= !do_write && !(w_hold_q || w_take) && !(bvalid && !bready);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         partner_q <= 32'h0000_0000;
         start_pulse <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         start_pulse <= 1'b0;
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= RESP_OKAY;
            case (aw_addr_q)
               ADDR_CTRL: begin
                  ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
                  start_pulse <= w_strb_q[0] && w_data_q[CTRL_START];
               end
               ADDR_PARTNER: partner_q <= merge(partner_q, w_data_q, w_strb_q);
               ADDR_STATUS, ADDR_CAP: bresp <= RESP_SLVERR;
               default: bresp <= RESP_SLVERR;
            endcase
         end
      end
   end

   // Low while a read answer is pending
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
      end else begin
         arready <= !(arvalid && arready) && (!rvalid || rready);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         case (araddr)
            ADDR_CTRL: rdata <= ctrl_q;
            ADDR_PARTNER: rdata <= partner_q;
            ADDR_STATUS: rdata <= status;
            ADDR_CAP: rdata <= cap;
            default: begin
               rdata <= 32'h0000_0000;
               rresp <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : lrw_axil
`default_nettype wire

// ### core/lrw_map.sv
// Lane crossbar: straight or reversed mapping of lane symbols.
// Assumes the select is steady while traffic flows.
`timescale 1ns/1ps
`default_nettype none
module lrw_map #(
   parameter int LANES = 16,
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reverse,
   input wire logic [LANES*W-1:0] din,
   output logic [LANES*W-1:0] dout
);
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            dout[i*W +: W] <= '0;
         end else if (reverse) begin
            dout[i*W +: W] <= din[(LANES-1-i)*W +: W];
         end else begin
            dout[i*W +: W] <= din[i*W +: W];
         end
      end
   end
endmodule : lrw_map
`default_nettype wire

// ### core/lrw_pkg.sv
// Package for the lane mapping and width negotiation block.
// Assumes a single 200 MHz core clock and an AXI4-Lite register master.
package lrw_pkg;
   localparam int MAX_LANES = 16;
   localparam int LANE_W = 8;
   localparam int CLK_MHZ = 200;
   // Settle time before a negotiated result is accepted
   localparam int SETTLE_NS = 100;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PARTNER = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CAP = 8'h0c;

   localparam int CTRL_START = 0;
   localparam int CTRL_REV_EN = 1;
   localparam int CTRL_PARTNER_REV = 2;
   localparam int CTRL_RST_ACT_LOW = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [4:0] {
      LRW_IDLE = 5'b00001,
      LRW_SETTLE = 5'b00010,
      LRW_UP = 5'b00100,
      LRW_FAIL = 5'b01000,
      LRW_HOLD = 5'b10000
   } lrw_state_t;

   typedef struct packed {
      logic [4:0] width;
      logic [1:0] speed;
      logic reversed;
      logic up;
      logic fail;
   } lrw_link_t;
endpackage : lrw_pkg

// ### core/lrw_top.sv
// Top of the lane reversal and width negotiation block.
// Assumes lane symbols synchronous to clk; partner capabilities are written
// into the partner register by the AXI4-Lite register master.
`timescale 1ns/1ps
`default_nettype none
module lrw_top
   import lrw_pkg::*;
#(
   parameter int LANES = lrw_pkg::MAX_LANES,
   parameter logic [1:0] MAX_SPEED = 2'd2,
   parameter bit RESET_ACTIVE_LOW = 1'b0,
   parameter bit ENDPOINT = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [7:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   input wire logic [LANES-1:0] rx_lane_seen,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] phy_rx_data,
   output logic [LANES*lrw_pkg::LANE_W-1:0] log_rx_data,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] log_tx_data,
   output logic [LANES*lrw_pkg::LANE_W-1:0] phy_tx_data,
   output lrw_pkg::lrw_link_t link_q
);
   import lrw_pkg::*;

   initial begin
      if (!(LANES == 1 || LANES == 2 || LANES == 4 || LANES == 8 || LANES == 16)) begin
         $error("LANES must be 1, 2, 4, 8 or 16");
      end
   end

   // Reset level picked at build time
   logic rst;
   assign rst = RESET_ACTIVE_LOW ? !sys_rst : sys_rst;

   logic [31:0] ctrl_q, partner_q;
   logic start_pulse;
   logic [31:0] status_w, cap_w;
   lrw_state_t state_q;
   logic [15:0] cnt_q;
   logic [4:0] width_q;
   logic [1:0] speed_q;
   logic rev_q;

   lrw_axil u_regs (
      .clk(clk),
      .rst(rst),
      .awaddr(s_axil_awaddr),
      .awvalid(s_axil_awvalid),
      .awready(s_axil_awready),
      .wdata(s_axil_wdata),
      .wstrb(s_axil_wstrb),
      .wvalid(s_axil_wvalid),
      .wready(s_axil_wready),
      .bresp(s_axil_bresp),
      .bvalid(s_axil_bvalid),
      .bready(s_axil_bready),
      .araddr(s_axil_araddr),
      .arvalid(s_axil_arvalid),
      .arready(s_axil_arready),
      .rdata(s_axil_rdata),
      .rresp(s_axil_rresp),
      .rvalid(s_axil_rvalid),
      .rready(s_axil_rready),
      .ctrl_q(ctrl_q),
      .partner_q(partner_q),
      .start_pulse(start_pulse),
      .status(status_w),
      .cap(cap_w)
   );

   // Partner word: [4:0] advertised width, [9:8] max speed
   logic [4:0] p_width;
   logic [1:0] p_speed;
   logic [4:0] own_width;
   logic [4:0] neg_width;
   logic [1:0] neg_speed;
   logic full_width;
   logic rev_allowed;
   logic lane0_straight, lane0_rev;
   logic rev_ok_width;

   assign p_width = partner_q[4:0];
   assign p_speed = partner_q[9:8];
   assign own_width = 5'(LANES);

   // Largest legal width not above the smaller of the partner's advertisement and own lane count
   function automatic logic [4:0] legal_width(input logic [4:0] w);
      if (w >= 5'd16) return 5'd16;
      else if (w >= 5'd8) return 5'd8;
      else if (w >= 5'd4) return 5'd4;
      else if (w >= 5'd2) return 5'd2;
      else return 5'd1;
   endfunction : legal_width

   assign neg_width = legal_width((p_width < own_width) ? p_width : own_width);
   assign neg_speed = (p_speed < MAX_SPEED) ? p_speed : MAX_SPEED;
   assign full_width = (neg_width == own_width);
   assign rev_ok_width = (LANES >= 4) && full_width;
   // Endpoint reversal gated by its enable and the partner's own capability
   assign rev_allowed = rev_ok_width && ctrl_q[CTRL_REV_EN]
                        && !(ENDPOINT && ctrl_q[CTRL_PARTNER_REV]);
   assign lane0_straight = rx_lane_seen[0];
   assign lane0_rev = rx_lane_seen[LANES-1];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= LRW_IDLE;
         cnt_q <= 16'h0000;
         width_q <= 5'h00;
         speed_q <= 2'h0;
         rev_q <= 1'b0;
      end else begin
         case (state_q)
            LRW_IDLE: begin
               if (start_pulse) begin
                  state_q <= LRW_SETTLE;
                  cnt_q <= 16'(SETTLE_CYC);
                  rev_q <= 1'b0;
               end
            end
            LRW_SETTLE: begin
               if (cnt_q > 16'h0001) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (lane0_straight) begin
                  state_q <= LRW_UP;
                  width_q <= neg_width;
                  speed_q <= neg_speed;
                  rev_q <= 1'b0;
               end else if (lane0_rev && rev_allowed) begin
                  state_q <= LRW_UP;
                  width_q <= neg_width;
                  speed_q <= neg_speed;
                  rev_q <= 1'b1;
               end else begin
                  // No lane zero on lane 0, and lane zero not on the last lane or reversal not allowed
                  state_q <= LRW_FAIL;
               end
            end
            LRW_UP: begin
               if (start_pulse) begin
                  // Retraining starts from the straight map
                  state_q <= LRW_SETTLE;
                  cnt_q <= 16'(SETTLE_CYC);
                  rev_q <= 1'b0;
               end else if (!rx_lane_seen[rev_q ? LANES-1 : 0]) begin
                  state_q <= LRW_HOLD;
               end
            end
            LRW_FAIL, LRW_HOLD: begin
               if (start_pulse) begin
                  state_q <= LRW_SETTLE;
                  cnt_q <= 16'(SETTLE_CYC);
                  rev_q <= 1'b0;
               end
            end
            default: state_q <= LRW_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_q <= '0;
      end else begin
         link_q.width <= (state_q == LRW_UP) ? width_q : 5'h00;
         link_q.speed <= speed_q;
         link_q.reversed <= rev_q && (state_q == LRW_UP);
         link_q.up <= (state_q == LRW_UP);
         link_q.fail <= (state_q == LRW_FAIL) || (state_q == LRW_HOLD);
      end
   end

   assign status_w = {17'h0_0000, state_q, 1'b0, rev_q, speed_q, 1'b0, width_q};
   assign cap_w = {22'h0, MAX_SPEED, 3'h0, own_width};

   lrw_map #(.LANES(LANES), .W(LANE_W)) u_rx_map (
      .clk(clk),
      .rst(rst),
      .reverse(rev_q),
      .din(phy_rx_data),
      .dout(log_rx_data)
   );

   lrw_map #(.LANES(LANES), .W(LANE_W)) u_tx_map (
      .clk(clk),
      .rst(rst),
      .reverse(rev_q),
      .din(log_tx_data),
      .dout(phy_tx_data)
   );
endmodule : lrw_top
`default_nettype wire

// ### testbench/lrw_partner.sv
// Link partner: drives lane activity and symbols onto the device lanes.
// Assumes the board wiring is fixed for the duration of one training.
`timescale 1ns/1ps
`default_nettype none
module lrw_partner #(
   parameter int LANES = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] adv_width,
   input wire logic rev_wired,
   output logic [LANES-1:0] rx_lane_seen,
   output logic [LANES*8-1:0] phy_rx_data
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt_q <= 4'h0;
      else cnt_q <= cnt_q + 4'h1;
   end
   for (genvar d = 0; d < LANES; d++) begin : g_lane
      logic [4:0] p;
      logic live;
      // Reversed board wiring; lanes past the width stay dark
      assign p = rev_wired ? 5'(LANES - 1 - d) : 5'(d);
      assign live = p < adv_width;
      // Lane zero, or a lane on its own number, counts as trained
      assign rx_lane_seen[d] = live && (p == 5'(d) || p == 5'h00);
      // Dark lanes toggle so a stale value never passes
      assign phy_rx_data[d*8 +: 8] = live ? {cnt_q, p[3:0]} : {~cnt_q, cnt_q};
   end
endmodule : lrw_partner
`default_nettype wire

// ### testbench/lrw_top_bench.sv
// Bench for the lane mapper: register master, training rows, map checks.
// Assumes lrw_top defaults: 16 lanes, speed code 2, endpoint.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module lrw_top_bench;
   import lrw_pkg::*;
   localparam int N = 16;
   typedef struct packed {
      logic [4:0] pw;
      logic [1:0] ps;
      logic [2:0] cfg;
      logic up;
      logic rev;
      logic [4:0] w;
      logic [1:0] sp;
   } lrw_row_t;
   // cfg: reversed wiring, reversal enable, partner reverses
   lrw_row_t rows [8] = '{'{16, 2, 3'b000, 1, 0, 16, 2}, '{8, 1, 3'b000, 1, 0, 8, 1},
      '{12, 2, 3'b000, 1, 0, 8, 2}, '{2, 0, 3'b010, 1, 0, 2, 0},
      '{16, 3, 3'b110, 1, 1, 16, 2}, '{16, 2, 3'b100, 0, 0, 0, 0},
      '{16, 2, 3'b111, 0, 0, 0, 0}, '{4, 2, 3'b110, 0, 0, 0, 0}};
   // Reset rises at time zero so the asynchronous reset edge is seen
   logic clk = 0, sys_rst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, wrev = 0;
   logic awr, wr, bv, arr, rv;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, rdata;
   logic [3:0] ws = 0;
   logic [4:0] pw = 0;
   logic [1:0] rsp, bresp, rresp;
   logic [N-1:0] seen;
   logic [N*8-1:0] prx, lrx, ltx, ptx;
   lrw_link_t link_q;
   int bad_count = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   lrw_top lrw_top_inst (.clk(clk), .sys_rst(sys_rst), .s_axil_awaddr(awa),
      .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(ws),
      .s_axil_wvalid(wv), .s_axil_wready(wr), .s_axil_bresp(bresp), .s_axil_bvalid(bv),
      .s_axil_bready(bry), .s_axil_araddr(ara), .s_axil_arvalid(arv),
      .s_axil_arready(arr), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
      .s_axil_rvalid(rv), .s_axil_rready(rry), .rx_lane_seen(seen), .phy_rx_data(prx),
      .log_rx_data(lrx), .log_tx_data(ltx), .phy_tx_data(ptx), .link_q(link_q));
   lrw_partner #(.LANES(N)) lrw_partner_inst (.clk(clk), .rst(sys_rst),
      .adv_width(pw), .rev_wired(wrev), .rx_lane_seen(seen), .phy_rx_data(prx));
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {awa, wd, ws, awv, wv, bry} <= {a, d, 4'hf, 3'b111};
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (bv !== 1'b1);
      rsp = bresp;
      bry <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      {ara, arv, rry} <= {a, 2'b11};
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      {rd, rsp} = {rdata, rresp};
      rry <= 1'b0;
   endtask : axr
   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK("link in reset", 10'h000, link_q)
      sys_rst <= 1'b0;
   endtask : do_reset
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize();
   end
   initial begin
      int n;
      for (int i = 0; i < N; i++) ltx[i*8 +: 8] = 8'h40 + 8'(i);
      for (int i = 0; i < 8; i++) begin
         do_reset();
         pw <= rows[i].pw;
         wrev <= rows[i].cfg[2];
         axw(ADDR_PARTNER, {22'h0, rows[i].ps, 3'h0, rows[i].pw});
         // Partner-reverses flag set means the enable must not take effect
         axw(ADDR_CTRL, {29'h0, rows[i].cfg[0], rows[i].cfg[1], 1'b1});
         n = 0;
         while (link_q.up !== 1'b1 && link_q.fail !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
         end
         `CHK("up", rows[i].up, link_q.up)
         `CHK("fail", ~rows[i].up, link_q.fail)
         if (rows[i].up) begin
            `CHK("width", rows[i].w, link_q.width)
            `CHK("speed", rows[i].sp, link_q.speed)
            `CHK("reversed", rows[i].rev, link_q.reversed)
            repeat (2) @(posedge clk);
            `CHK("rx lane0", 4'h0, lrx[3:0])
            `CHK("tx lane0", rows[i].rev ? 8'h4f : 8'h40, ptx[7:0])
            `CHK("tx lane15", rows[i].rev ? 8'h40 : 8'h4f, ptx[N*8-1 -: 8])
            axr(ADDR_STATUS);
            `CHK("status", {17'h0, LRW_UP, 1'b0, rows[i].rev, rows[i].sp, 1'b0, rows[i].w}, rd)
            `CHK("status resp", RESP_OKAY, rsp)
         end
         $display("row %0d done", i);
      end
      // Retrain a reversed link on straight wiring, then lose the partner
      do_reset();
      pw <= 5'd16;
      wrev <= 1'b1;
      axw(ADDR_PARTNER, 32'h0000_0210);
      axw(ADDR_CTRL, 32'h0000_0003);
      repeat (30) @(posedge clk);
      `CHK("rev up", 1'b1, link_q.reversed)
      wrev <= 1'b0;
      axw(ADDR_CTRL, 32'h0000_0003);
      repeat (3) @(posedge clk);
      `CHK("retrain map", 8'h40, ptx[7:0])
      repeat (30) @(posedge clk);
      `CHK("retrain up", 1'b1, link_q.up)
      `CHK("retrain rev", 1'b0, link_q.reversed)
      pw <= 5'd0;
      repeat (3) @(posedge clk);
      `CHK("lost up", 1'b0, link_q.up)
      `CHK("lost fail", 1'b1, link_q.fail)
      $display("retrain test done");
      do_reset();
      axr(ADDR_CTRL);
      `CHK("ctrl reset", CTRL_RESET, rd)
      axr(ADDR_CAP);
      `CHK("cap", 32'h0000_0210, rd)
      axr(8'h10);
      `CHK("unmapped read", RESP_SLVERR, rsp)
      axw(ADDR_STATUS, 32'h0000_ffff);
      `CHK("status write", RESP_SLVERR, rsp)
      $display("register test done");
      summarize();
   end
endmodule : lrw_top_bench
bind lrw_top lrw_top_properties #(.LANES(LANES), .MAX_SPEED(MAX_SPEED)) lrw_props_inst (
   .clk(clk), .sys_rst(sys_rst), .s_axil_arvalid(s_axil_arvalid),
   .s_axil_arready(s_axil_arready), .s_axil_rvalid(s_axil_rvalid),
   .phy_rx_data(phy_rx_data), .log_rx_data(log_rx_data), .log_tx_data(log_tx_data),
   .phy_tx_data(phy_tx_data), .link_q(link_q));
`default_nettype wire

// ### testbench/lrw_top_properties.sv
// Checker for the lane mapper top: lane map, link status, read answer.
// Assumes the default reset polarity (sys_rst active high).
`timescale 1ns/1ps
`default_nettype none
module lrw_top_properties
   import lrw_pkg::*;
#(
   parameter int LANES = 16,
   parameter logic [1:0] MAX_SPEED = 2'd2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axil_arvalid,
   input wire logic s_axil_arready,
   input wire logic s_axil_rvalid,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] phy_rx_data,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] log_rx_data,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] log_tx_data,
   input wire logic [LANES*lrw_pkg::LANE_W-1:0] phy_tx_data,
   input wire lrw_pkg::lrw_link_t link_q
);
   import lrw_pkg::*;
   localparam int W = lrw_pkg::LANE_W;
   localparam int T = (LANES - 1) * W;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Past values straddling reset are not compared
   property p_rev_map;
      !$past(sys_rst) && link_q.reversed && $past(link_q.reversed) |->
         log_rx_data[W-1:0] == $past(phy_rx_data[T +: W]) &&
         phy_tx_data[W-1:0] == $past(log_tx_data[T +: W]);
   endproperty
   a_rev_map: assert property (p_rev_map)
      else $error("reversed lane map wrong");
   property p_str_map;
      !$past(sys_rst) && !link_q.reversed && !$past(link_q.reversed) |->
         log_rx_data[W-1:0] == $past(phy_rx_data[W-1:0]) &&
         phy_tx_data[T +: W] == $past(log_tx_data[T +: W]);
   endproperty
   a_str_map: assert property (p_str_map)
      else $error("straight lane map wrong");
   property p_rev_full;
      link_q.reversed |-> link_q.width == LANES && LANES >= 4;
   endproperty
   a_rev_full: assert property (p_rev_full)
      else $error("reversal below full width");
   property p_width;
      link_q.up |-> link_q.width <= LANES && $onehot(link_q.width);
   endproperty
   a_width: assert property (p_width)
      else $error("negotiated width illegal");
   property p_speed;
      link_q.up |-> link_q.speed <= MAX_SPEED;
   endproperty
   a_speed: assert property (p_speed)
      else $error("speed above own maximum");
   property p_nofail;
      link_q.up |-> !link_q.fail;
   endproperty
   a_nofail: assert property (p_nofail)
      else $error("link up and failed together");
   property p_rst;
      disable iff (1'b0) sys_rst |-> link_q == '0 && !s_axil_rvalid;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared in reset");
   property p_rd_lat;
      s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   c_rev: cover property (link_q.up && link_q.reversed);
   c_fail: cover property (link_q.fail);
   c_down: cover property (link_q.up && link_q.width < LANES);
endmodule : lrw_top_properties
`default_nettype wire
